/* File: logic/rnic_defs.vh */
// Register map, field positions, reset values and vectors of the reset and interrupt block
`ifndef RNIC_DEFS_VH
`define RNIC_DEFS_VH

// Word indices; byte address is four times the index
`define RNIC_IDX_WDCTL 3'h0
`define RNIC_IDX_IE 3'h1
`define RNIC_IDX_IFG 3'h2
`define RNIC_IDX_PEN 3'h3
`define RNIC_IDX_OSC 3'h4
`define RNIC_IDX_STAT 3'h5

// Watchdog control fields
`define RNIC_WD_NMIFN 0
`define RNIC_WD_EDGE 1
`define RNIC_WD_INTV 2
`define RNIC_WDCTL_RST 3'h0

// Enable fields
`define RNIC_IE_PIN 0
`define RNIC_IE_OSC 1
`define RNIC_IE_FLASH 2
`define RNIC_IE_SUPERVISOR_RESET_ENABLE 3
`define RNIC_IE_RST 4'h0

// Flag fields
`define RNIC_IFG_PIN 0
`define RNIC_IFG_OSC 1
`define RNIC_IFG_FLASH 2
`define RNIC_IFG_WDT 3
`define RNIC_IFG_RST 4'h0

// Oscillator control fields
`define RNIC_OSC_XT1HF 0
`define RNIC_OSC_XT2ON 1
`define RNIC_OSC_RST 2'h0

// Status fields: clear-cause flags and live levels
`define RNIC_ST_CWDT 0
`define RNIC_ST_CWKEY 1
`define RNIC_ST_CFKEY 2
`define RNIC_ST_PIN 8
`define RNIC_ST_NMIFN 9
`define RNIC_CAUSE_RST 3'h0

// Vectors and chain
`define RNIC_VEC_RESET 16'hfffe
`define RNIC_VEC_NMI 16'hfffc
`define RNIC_VEC_BASE 16'hffe0
`define RNIC_NSLOT 14
`define RNIC_SLOT_WDT 4'ha
`define RNIC_PEN_RST 14'h0000

`endif

/* File: logic/rnic_ctrl.v */
// Reset generation, reset/NMI pin control and interrupt request logic
// Notes on behaviour
// - Power-on reset from power-up, pin, supervisor
// - Power-on reset implies clear, never reverse
// - Clear on watchdog expiry and key violations
// - Power-up alone clears status; power-on clears pin reset, watchdog mode
// - After reset fetch starts at reset vector
// - Chain position fixes priority, nearest wins
// - Non-maskable requests ignore global enable
// - Accepted NMI clears three enables, vectors
// - NMI sources: pin edge, oscillator, flash
// - Watchdog control bit selects pin function
// - Reset function holds CPU while pin low
// - Selected pin edge sets flag, enable requests
// - Any clear returns pin to reset function
// - Edge select change may trigger only in NMI
// - Oscillator fault sets flag, enable requests
// - Clear forces low frequency, second osc off
// - Flash violation sets flag, enable requests
// - Maskable needs own and global enable
// - Interval-mode overflow is maskable source only
// - Acceptance clears single-source flags only
//
// Chosen here: the register offsets and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
`include "rnic_defs.vh"

module rnic_ctrl (
    input wire clk,
    input wire sys_rst,
    input wire [4:0] avsAddress,
    input wire avsRead,
    input wire avsWrite,
    input wire [31:0] avsWriteData,
    output reg [31:0] avsReadData,
    output wire avsWaitrequest,
    input wire rstNmiPin,
    input wire svsLow,
    input wire wdtOverflow,
    input wire wdtKeyViol,
    input wire flashKeyViol,
    input wire oscFault,
    input wire flashAccViol,
    input wire [`RNIC_NSLOT-1:0] periphIrq,
    input wire globalIrqEnable,
    input wire cpuAck,
    output reg porOut,
    output reg pucOut,
    output reg irqReq,
    output reg irqNmi,
    output reg [15:0] irqVector,
    output reg [`RNIC_NSLOT-1:0] periphAck,
    output wire xt1HfMode,
    output wire xt2On,
    output wire wdtIntervalMode
);

    // Write strobe for one word; keeps every decode the same shape
    function rnic_hit;
        input wr;
        input [2:0] idx;
        input [2:0] want;
        begin
            rnic_hit = wr & (idx == want);
        end
    endfunction

    // Vector word of a chain slot: two bytes per slot above the base
    function [15:0] rnic_slot_vec;
        input [3:0] slot;
        begin
            rnic_slot_vec = `RNIC_VEC_BASE + {11'h000, slot, 1'b0};
        end
    endfunction

    // Highest pending slot wins; top index sits nearest the CPU
    function [4:0] rnic_pick;
        input [`RNIC_NSLOT-1:0] req;
        integer k;
        begin
            rnic_pick = 5'h00;
            for (k = 0; k < `RNIC_NSLOT; k = k + 1) begin
                if (req[k]) begin
                    rnic_pick = {1'b1, k[3:0]};
                end
            end
        end
    endfunction

    reg [2:0] wdCtl;
    reg [3:0] irqEn;
    reg [3:0] flags;
    reg [`RNIC_NSLOT-1:0] periphEn;
    reg [1:0] oscCtl;
    reg [2:0] cause;
    reg [3:0] irqSlot;

    reg pinMeta;
    reg pinSync;
    reg pinDetPrev;
    reg svsMeta;
    reg svsSync;
    reg busAck;

    reg [31:0] next_readData;
    reg [`RNIC_NSLOT-1:0] maskedReq;

    wire busReq;
    wire wrEn;
    wire [2:0] regIdx;
    wire pinDet;
    wire pinEdge;
    wire wdtExpire;
    wire wdtInterval;
    wire porNow;
    wire pucNow;
    wire nmiReq;
    wire [4:0] pick;
    wire ackNmi;
    wire ackSlot;
    wire [3:0] flagSet;
    wire [3:0] flagClr;
    wire [2:0] causeClr;

    wire hitWdCtl;
    wire hitIe;
    wire hitIfg;
    wire hitPen;
    wire hitOsc;
    wire hitStat;

    reg [2:0] next_wdCtl;
    reg [3:0] next_irqEn;
    reg [`RNIC_NSLOT-1:0] next_periphEn;
    reg [1:0] next_oscCtl;
    reg [3:0] next_flags;
    reg [2:0] next_cause;
    reg next_irqReq;
    reg next_irqNmi;
    reg [3:0] next_irqSlot;
    reg [15:0] next_irqVector;
    reg [`RNIC_NSLOT-1:0] next_periphAck;

    // Two-stage synchronisers; only the second stage is read
    always @(posedge clk) begin
        if (sys_rst) begin
            pinMeta <= 1'b1;
            pinSync <= 1'b1;
            svsMeta <= 1'b0;
            svsSync <= 1'b0;
        end else begin
            pinMeta <= rstNmiPin;
            pinSync <= pinMeta;
            svsMeta <= svsLow;
            svsSync <= svsMeta;
        end
    end

    // Edge detect on level xor edge select: an edge select flip while in NMI
    // function looks like an edge; before that the history just tracks along
    assign pinDet = pinSync ^ wdCtl[`RNIC_WD_EDGE];
    assign pinEdge = wdCtl[`RNIC_WD_NMIFN] & pinDet & ~pinDetPrev;

    always @(posedge clk) begin
        if (sys_rst) begin
            pinDetPrev <= 1'b1;
        end else begin
            pinDetPrev <= pinDet;
        end
    end

    // Reset sources
    assign wdtExpire = wdtOverflow & ~wdCtl[`RNIC_WD_INTV];
    assign wdtInterval = wdtOverflow & wdCtl[`RNIC_WD_INTV];
    assign porNow = sys_rst
        | (~pinSync & ~wdCtl[`RNIC_WD_NMIFN])
        | (svsSync & irqEn[`RNIC_IE_SUPERVISOR_RESET_ENABLE]);
    assign pucNow = porNow | wdtExpire | wdtKeyViol | flashKeyViol;

    always @(posedge clk) begin
        porOut <= porNow;
        pucOut <= pucNow;
    end

    // Bus slave: one wait cycle, then completion
    assign busReq = avsRead | avsWrite;
    assign avsWaitrequest = busReq & ~busAck;
    assign wrEn = avsWrite & busAck;
    assign regIdx = avsAddress[4:2];

    // Writes land only at the completion edge, never in the wait cycle
    assign hitWdCtl = rnic_hit(wrEn, regIdx, `RNIC_IDX_WDCTL);
    assign hitIe = rnic_hit(wrEn, regIdx, `RNIC_IDX_IE);
    assign hitIfg = rnic_hit(wrEn, regIdx, `RNIC_IDX_IFG);
    assign hitPen = rnic_hit(wrEn, regIdx, `RNIC_IDX_PEN);
    assign hitOsc = rnic_hit(wrEn, regIdx, `RNIC_IDX_OSC);
    assign hitStat = rnic_hit(wrEn, regIdx, `RNIC_IDX_STAT);

    always @(posedge clk) begin
        if (sys_rst) begin
            busAck <= 1'b0;
        end else begin
            busAck <= busReq & ~busAck;
        end
    end

    always @* begin
        next_readData = 32'h00000000;
        case (regIdx)
            `RNIC_IDX_WDCTL: next_readData[2:0] = wdCtl;
            `RNIC_IDX_IE: next_readData[3:0] = irqEn;
            `RNIC_IDX_IFG: next_readData[3:0] = flags;
            `RNIC_IDX_PEN: next_readData[`RNIC_NSLOT-1:0] = periphEn;
            `RNIC_IDX_OSC: next_readData[1:0] = oscCtl;
            `RNIC_IDX_STAT: begin
                next_readData[2:0] = cause;
                next_readData[`RNIC_ST_PIN] = pinSync;
                next_readData[`RNIC_ST_NMIFN] = wdCtl[`RNIC_WD_NMIFN];
            end
            default: next_readData = 32'h00000000;
        endcase
    end

    // Read data latched one edge early so it stands at completion
    always @(posedge clk) begin
        if (sys_rst) begin
            avsReadData <= 32'h00000000;
        end else if (avsRead & ~busAck) begin
            avsReadData <= next_readData;
        end
    end

    // Acceptance of the registered request
    assign ackNmi = cpuAck & irqReq & irqNmi;
    assign ackSlot = cpuAck & irqReq & ~irqNmi;

    // Control registers; power-on clears all, a clear only the volatile part
    always @* begin
        next_wdCtl = wdCtl;
        next_irqEn = irqEn;
        next_periphEn = periphEn;
        next_oscCtl = oscCtl;
        if (porNow) begin
            next_wdCtl = `RNIC_WDCTL_RST;
            next_irqEn = `RNIC_IE_RST;
            next_periphEn = `RNIC_PEN_RST;
            next_oscCtl = `RNIC_OSC_RST;
        end else if (pucNow) begin
            next_wdCtl = `RNIC_WDCTL_RST;
            next_irqEn[2:0] = 3'h0;
            next_periphEn = `RNIC_PEN_RST;
            next_oscCtl = `RNIC_OSC_RST;
        end else begin
            if (hitWdCtl) begin
                next_wdCtl = avsWriteData[2:0];
            end
            if (hitIe) begin
                next_irqEn = avsWriteData[3:0];
            end
            if (hitPen) begin
                next_periphEn = avsWriteData[`RNIC_NSLOT-1:0];
            end
            if (hitOsc) begin
                next_oscCtl = avsWriteData[1:0];
            end
            // Acceptance overrides a same-cycle enable write
            if (ackNmi) begin
                next_irqEn[2:0] = 3'h0;
            end
        end
    end

    // No reset branch needed: porNow already carries sys_rst
    always @(posedge clk) begin
        wdCtl <= next_wdCtl;
        irqEn <= next_irqEn;
        periphEn <= next_periphEn;
        oscCtl <= next_oscCtl;
    end

    // Sticky flags: set beats clear; enables never touch them
    assign flagSet = {wdtInterval, flashAccViol, oscFault, pinEdge};
    assign flagClr = (hitIfg ? avsWriteData[3:0] : 4'h0)
        | {(ackSlot && irqSlot == `RNIC_SLOT_WDT), 3'h0};
    assign causeClr = hitStat ? avsWriteData[2:0] : 3'h0;

    // Flags and causes survive a clear so software can read why it happened
    always @* begin
        next_flags = (flags & ~flagClr) | flagSet;
        next_cause = (cause & ~causeClr) | {flashKeyViol, wdtKeyViol, wdtExpire};
        if (sys_rst) begin
            next_flags = `RNIC_IFG_RST;
            next_cause = `RNIC_CAUSE_RST;
        end
    end

    always @(posedge clk) begin
        flags <= next_flags;
        cause <= next_cause;
    end

    // Request gating
    assign nmiReq = |(flags[2:0] & irqEn[2:0]);

    always @* begin
        maskedReq = periphIrq & periphEn;
        maskedReq[`RNIC_SLOT_WDT] = flags[`RNIC_IFG_WDT] & periphEn[`RNIC_SLOT_WDT];
        if (!globalIrqEnable) begin
            maskedReq = {`RNIC_NSLOT{1'b0}};
        end
    end

    assign pick = rnic_pick(maskedReq);

    // Registered request and vector to the CPU
    // Later branches win: clear over NMI over maskable
    always @* begin
        next_irqReq = pick[4];
        next_irqNmi = 1'b0;
        next_irqSlot = pick[3:0];
        next_irqVector = `RNIC_VEC_RESET;
        if (pick[4]) begin
            next_irqVector = rnic_slot_vec(pick[3:0]);
        end
        if (nmiReq) begin
            next_irqReq = 1'b1;
            next_irqNmi = 1'b1;
            next_irqSlot = 4'h0;
            next_irqVector = `RNIC_VEC_NMI;
        end
        if (pucNow) begin
            next_irqReq = 1'b0;
            next_irqNmi = 1'b0;
            next_irqSlot = 4'h0;
            next_irqVector = `RNIC_VEC_RESET;
        end
    end

    always @(posedge clk) begin
        irqReq <= next_irqReq;
        irqNmi <= next_irqNmi;
        irqSlot <= next_irqSlot;
        irqVector <= next_irqVector;
    end

    // Acknowledge pulse lets a peripheral drop its single-source flag
    always @* begin
        next_periphAck = {`RNIC_NSLOT{1'b0}};
        if (ackSlot) begin
            next_periphAck = {{(`RNIC_NSLOT-1){1'b0}}, 1'b1} << irqSlot;
        end
        if (pucNow) begin
            next_periphAck = {`RNIC_NSLOT{1'b0}};
        end
    end

    always @(posedge clk) begin
        periphAck <= next_periphAck;
    end

    assign xt1HfMode = oscCtl[`RNIC_OSC_XT1HF];
    assign xt2On = oscCtl[`RNIC_OSC_XT2ON];
    assign wdtIntervalMode = wdCtl[`RNIC_WD_INTV];

endmodule // rnic_ctrl
`default_nettype wire

/* File: sim/rnic_ctrl_properties.sv */
// Port-level assertions for the reset and interrupt block
`timescale 1ns/10ps
`default_nettype none
module rnic_ctrl_props (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wdtOverflow,
    input wire logic wdtKeyViol,
    input wire logic flashKeyViol,
    input wire logic globalIrqEnable,
    input wire logic cpuAck,
    input wire logic porOut,
    input wire logic pucOut,
    input wire logic irqReq,
    input wire logic irqNmi,
    input wire logic [15:0] irqVector,
    input wire logic [13:0] periphAck,
    input wire logic xt1HfMode,
    input wire logic xt2On,
    input wire logic wdtIntervalMode
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    property p_por_clear; porOut |-> pucOut; endproperty
    a_por_clear: assert property (p_por_clear) else $error("reset without clear");
    property p_wkey; wdtKeyViol |=> pucOut; endproperty
    a_wkey: assert property (p_wkey) else $error("no clear on key");
    property p_fkey; flashKeyViol |=> pucOut; endproperty
    a_fkey: assert property (p_fkey) else $error("no clear on flash key");
    property p_wdt; wdtOverflow && !wdtIntervalMode |=> pucOut; endproperty
    a_wdt: assert property (p_wdt) else $error("no clear on expiry");
    property p_clr_vec; pucOut |-> irqVector == 16'hfffe && !irqReq; endproperty
    a_clr_vec: assert property (p_clr_vec) else $error("bad vector in clear");
    property p_clr_osc; pucOut |=> !xt1HfMode && !xt2On; endproperty
    a_clr_osc: assert property (p_clr_osc) else $error("oscillators not reset");
    property p_nmi_vec; irqReq && irqNmi |-> irqVector == 16'hfffc; endproperty
    a_nmi_vec: assert property (p_nmi_vec) else $error("bad nmi vector");
    property p_gie; irqReq && !irqNmi |-> $past(globalIrqEnable); endproperty
    a_gie: assert property (p_gie) else $error("maskable without enable");
    property p_pack; |periphAck |-> $past(cpuAck) && $onehot(periphAck); endproperty
    a_pack: assert property (p_pack) else $error("stray slot ack");
endmodule // rnic_ctrl_props
bind rnic_ctrl rnic_ctrl_props rnic_ctrl_props_i (.clk, .sys_rst, .wdtOverflow, .wdtKeyViol,
    .flashKeyViol, .globalIrqEnable, .cpuAck, .porOut, .pucOut, .irqReq, .irqNmi, .irqVector,
    .periphAck, .xt1HfMode, .xt2On, .wdtIntervalMode);
`default_nettype wire

/* File: sim/rnic_cpu_model.sv */
// CPU side model: accepts a pending request when allowed
`timescale 1ns/10ps
`default_nettype none
module rnic_cpu_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic irqReq,
    input wire logic ackOn,
    output logic cpuAck
);
    logic [2:0] gap;
    // Gap keeps acks five cycles apart, the block cannot take them closer
    always @(posedge clk) begin
        if (sys_rst) begin
            cpuAck <= 1'h0;
            gap <= 3'h0;
        end else begin
            cpuAck <= ackOn && irqReq && gap == 3'h0;
            gap <= (ackOn && irqReq && gap == 3'h0) ? 3'h4 : gap - {2'h0, gap != 3'h0};
        end
    end
endmodule // rnic_cpu_model
`default_nettype wire

/* File: sim/rnic_ctrl_test.sv */
// Self-checking bench for the reset and interrupt block
`timescale 1ns/10ps
`default_nettype none
module rnic_ctrl_test;
    logic clk = 0, sys_rst = 1, avsRead = 0, avsWrite = 0, pin = 1, global_irq_enable = 0, ackOn = 0, osc = 0;
    logic [4:0] adr = 5'h0;
    logic [31:0] wd = 32'h0, q;
    logic [2:0] pv = 3'h0;
    logic [13:0] pirq = 14'h0;
    wire [31:0] rd;
    wire [15:0] vec;
    wire wr, por, power_up_clear, req, nmi, ack, xt1, xt2, wim;
    wire [13:0] pack;
    logic [13:0] packSeen = 14'h0;
    always @(posedge clk) packSeen <= packSeen | pack;
    integer err_count = 0, tests_run = 0;
    initial forever #5 clk = ~clk;
    rnic_ctrl rnic_ctrl_i (.clk(clk), .sys_rst(sys_rst), .avsAddress(adr), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWriteData(wd), .avsReadData(rd), .avsWaitrequest(wr),
        .rstNmiPin(pin), .svsLow(1'h0), .wdtOverflow(pv[0]), .wdtKeyViol(pv[1]),
        .flashKeyViol(pv[2]), .oscFault(osc), .flashAccViol(1'h0), .periphIrq(pirq),
        .globalIrqEnable(global_irq_enable), .cpuAck(ack), .porOut(por), .pucOut(power_up_clear), .irqReq(req),
        .irqNmi(nmi), .irqVector(vec), .periphAck(pack), .xt1HfMode(xt1), .xt2On(xt2),
        .wdtIntervalMode(wim));
    rnic_cpu_model rnic_cpu_model_i (.clk(clk), .sys_rst(sys_rst), .irqReq(req),
        .ackOn(ackOn), .cpuAck(ack));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        integer n;
        @(posedge clk);
        adr <= a;
        wd <= d;
        avsWrite <= w;
        avsRead <= !w;
        n = 0;
        // Hold until an edge samples waitrequest low; take data at that edge
        @(posedge clk);
        while (wr !== 1'h0 && n < 50) begin
            @(posedge clk);
            n = n + 1;
        end
        if (n >= 50) begin
            err_count = err_count + 1;
            $display("MISMATCH t=%0t bus never answered", $time);
        end
        q = rd;
        avsWrite <= 1'h0;
        avsRead <= 1'h0;
    endtask
    task rdchk(input logic [4:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        chk(q, e);
    endtask
    task cyc(input integer k);
        repeat (k) @(posedge clk);
        @(negedge clk);
    endtask
    task tally_and_finish;
        $display("COUNTS tests %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task t_reset;
        chk({por, power_up_clear, vec}, {2'h0, 16'hfffe});
        rdchk(5'h00, 32'h0);
        rdchk(5'h18, 32'h0);
        bus(1'h1, 5'h10, 32'h3);
        rdchk(5'h10, 32'h3);
        chk({xt1, xt2}, 2'h3);
        bus(1'h1, 5'h00, 32'h4);
        cyc(1);
        chk(wim, 1'h1);
        @(posedge clk);
        pv <= 3'h1;
        @(posedge clk);
        pv <= 3'h0;
        @(negedge clk);
        chk(power_up_clear, 1'h0);
        rdchk(5'h08, 32'h8);
        bus(1'h1, 5'h08, 32'h8);
        bus(1'h1, 5'h00, 32'h0);
        $display("reset test end");
    endtask
    task t_pin;
        bus(1'h1, 5'h00, 32'h1);
        bus(1'h1, 5'h04, 32'h1);
        @(posedge clk);
        pin <= 1'h0;
        cyc(4);
        chk(por, 1'h0);
        @(posedge clk);
        pin <= 1'h1;
        cyc(5);
        chk({req, nmi, vec}, {2'h3, 16'hfffc});
        @(posedge clk);
        ackOn <= 1'h1;
        repeat (3) @(posedge clk);
        ackOn <= 1'h0;
        rdchk(5'h04, 32'h0);
        rdchk(5'h08, 32'h1);
        bus(1'h1, 5'h08, 32'h1);
        rdchk(5'h08, 32'h0);
        $display("pin test end");
    endtask
    task t_osc;
        @(posedge clk);
        osc <= 1'h1;
        @(posedge clk);
        osc <= 1'h0;
        cyc(2);
        chk(req, 1'h0);
        rdchk(5'h08, 32'h2);
        bus(1'h1, 5'h04, 32'h2);
        cyc(2);
        chk({req, nmi}, 2'h3);
        bus(1'h1, 5'h08, 32'h2);
        $display("osc test end");
    endtask
    task t_mask;
        bus(1'h1, 5'h0c, 32'h28);
        @(posedge clk);
        pirq <= 14'h0028;
        cyc(3);
        chk(req, 1'h0);
        @(posedge clk);
        global_irq_enable <= 1'h1;
        cyc(3);
        chk({req, nmi, vec}, {2'h2, 16'hffea});
        @(posedge clk);
        ackOn <= 1'h1;
        repeat (2) @(posedge clk);
        pirq <= 14'h0;
        global_irq_enable <= 1'h0;
        ackOn <= 1'h0;
        cyc(2);
        chk(packSeen, 14'h0020);
        $display("mask test end");
    endtask
    task t_clear;
        integer k;
        bus(1'h1, 5'h00, 32'h1);
        for (k = 0; k < 3; k = k + 1) begin
            @(posedge clk);
            pv <= 3'h1 << k;
            @(posedge clk);
            pv <= 3'h0;
            @(negedge clk);
            chk({por, power_up_clear}, 2'h1);
            cyc(3);
            rdchk(5'h14, 32'h100 | ((32'h2 << k) - 32'h1));
        end
        rdchk(5'h10, 32'h0);
        chk({xt1, xt2}, 2'h0);
        @(posedge clk);
        pin <= 1'h0;
        cyc(4);
        chk({por, power_up_clear, vec}, {2'h3, 16'hfffe});
        @(posedge clk);
        pin <= 1'h1;
        cyc(5);
        chk({por, power_up_clear}, 2'h0);
        $display("clear test end");
    endtask
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'h0;
        cyc(2);
        t_reset;
        t_pin;
        t_osc;
        t_mask;
        t_clear;
        tally_and_finish;
    end
    initial begin
        #20000;
        err_count = err_count + 1;
        tally_and_finish;
    end
endmodule // rnic_ctrl_test
`default_nettype wire
